/* hdl/angle_status_regs.sv */
// Angle, turns and fault status register bank with summary error
//
// Overview of operation
// - Angle in bits 12:1, bit 0 zero
// - Angle direction follows rotation polarity
// - Turns tally signed 12 bits, +/-1280
// - Step per 45 or 180 degree crossing
// - Tally up or down by polarity direction
// - Tally overflow sets primary bit 3
// - Flags sticky until clear or reset
// - Unmasked flag drives summary error
// - Masked flag still recorded in register
// - Uncorrectable memory error sets bit 6
// - Corrected memory error sets bit 5
// - Overtemperature sets bit 4
// - Logic timer fault sets bit 2
// - Field below threshold sets bit 1
// - Supply loss sets bit 0, resets one
// - Link fault sets secondary bit 6
// - Logic self-test fail sets bit 4
// - Front-end self-test fail sets bit 3
// - Flag clear command acts, reads zero
module angle_status_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic        rd_en_i,
  input  wire logic [5:0]  rd_addr_i,
  output logic      [12:0] rd_data_o,
  output logic             rd_valid_o,
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_addr_i,
  input  wire logic [12:0] wr_data_i,
  // Angle path
  input  wire logic        angle_valid_i,
  input  wire logic [11:0] angle_raw_i,
  input  wire logic        rotation_polarity_i,
  input  wire logic        tally_step_select_i,
  // Field monitor
  input  wire logic        field_valid_i,
  input  wire logic [10:0] field_level_i,
  input  wire logic [10:0] field_loss_threshold_i,
  // Fault events
  input  wire logic        nvm_uncorrectable_i,
  input  wire logic        nvm_corrected_i,
  input  wire logic        overtemp_i,
  input  wire logic        logic_fault_i,
  input  wire logic        supply_loss_i,
  input  wire logic        transport_exit_i,
  input  wire logic        serial_link_fault_i,
  input  wire logic        logic_selftest_fail_i,
  input  wire logic        frontend_selftest_fail_i,
  // Masks
  input  wire logic [6:0]  fault_mask_primary_i,
  input  wire logic [6:0]  fault_mask_secondary_i,
  output logic             summary_error_o
);

  // ==========================================================
  // Decoding helpers
  // Sector index of an angle at the selected step size
  function automatic logic [2:0] sector_of(
    input logic [11:0] angle_reading,
    input logic        fine
  );
    logic [2:0] s;
    s = fine ? angle_reading[11:9] : {2'b00, angle_reading[11]};
    return s;
  endfunction

  function automatic logic addr_is(
    input logic [5:0] a,
    input logic [5:0] ofs
  );
    return a == ofs;
  endfunction

  // Any flag that its mask leaves open raises the summary
  function automatic logic any_unmasked(
    input logic [6:0] flags,
    input logic [6:0] mask
  );
    return |(flags & ~mask);
  endfunction

  // Set wins over clear, so an event in the clearing cycle is kept
  function automatic logic [6:0] sticky_next(
    input logic [6:0] cur,
    input logic [6:0] evt,
    input logic       clr
  );
    logic [6:0] n;
    n = clr ? evt : (cur | evt);
    return n;
  endfunction

  // ==========================================================
  // Declarations
  tally_if tif ();

  logic [11:0]                angle_q;
  logic [11:0]                angle_d;
  logic [11:0]                prev_angle_q;
  logic [11:0]                delta;
  logic                       sector_change;
  logic                       forward;
  angle_status_pkg::tally_state_t tstate_q;
  logic [6:0]                 primary_q;
  logic [6:0]                 primary_set;
  logic [6:0]                 secondary_q;
  logic [6:0]                 secondary_set;
  logic [6:0]                 secondary_view;
  logic                       flag_clear;
  logic                       summary_q;
  logic [12:0]                rd_data_q;
  logic                       rd_valid_q;
  logic [12:0]                rd_mux;
  logic [2:0]                 sync_q [angle_status_pkg::ASYNC_N];
  logic [1:0]                 async_raw;
  logic [1:0]                 async_lvl;
  logic                       lvl_q [angle_status_pkg::ASYNC_N];
  logic                       pol_q;
  logic                       pol_change;

  // ==========================================================
  // Pin synchronisers
  // Analog comparator levels; only stages two and three are looked at
  assign async_raw[angle_status_pkg::ASYNC_TEMP]   = overtemp_i;
  assign async_raw[angle_status_pkg::ASYNC_SUPPLY] = supply_loss_i;

  generate
    for (genvar g = 0; g < angle_status_pkg::ASYNC_N; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync_q[g] <= 3'h0;
        end else begin
          sync_q[g] <= {sync_q[g][1:0], async_raw[g]};
        end
      end
      // The level moves only once stages two and three agree
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          lvl_q[g] <= 1'b0;
        end else if (sync_q[g][1] == sync_q[g][2]) begin
          lvl_q[g] <= sync_q[g][2];
        end
      end
      assign async_lvl[g] = lvl_q[g];
    end
  endgenerate

  // ==========================================================
  // Angle capture
  // Reversed polarity mirrors the angle so it runs the other way
  assign angle_d = rotation_polarity_i ? (12'h000 - angle_raw_i)
                                       : angle_raw_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      angle_q <= 12'h000;
    end else if (angle_valid_i) begin
      angle_q <= angle_d;
    end
  end

  // ==========================================================
  // Crossing detection
  // Direction comes from the short way round between two samples,
  // so samples must be closer than half a turn apart
  assign delta         = angle_d - prev_angle_q;
  assign forward       = ~delta[11];
  assign sector_change = sector_of(angle_d, tally_step_select_i)
                      != sector_of(prev_angle_q, tally_step_select_i);

  // A polarity flip mirrors every later sample, so the reference is taken
  // again rather than counting a crossing the target never made
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pol_q <= 1'b0;
    end else begin
      pol_q <= rotation_polarity_i;
    end
  end

  assign pol_change = rotation_polarity_i != pol_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tstate_q <= angle_status_pkg::TALLY_WAIT;
    end else begin
      case (tstate_q)
        angle_status_pkg::TALLY_WAIT: begin
          if (angle_valid_i && !pol_change) begin
            tstate_q <= angle_status_pkg::TALLY_TRACK;
          end
        end
        angle_status_pkg::TALLY_TRACK: begin
          if (pol_change) begin
            tstate_q <= angle_status_pkg::TALLY_WAIT;
          end
        end
        default: begin
          tstate_q <= angle_status_pkg::TALLY_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_angle_q <= 12'h000;
    end else if (angle_valid_i) begin
      prev_angle_q <= angle_d;
    end
  end

  assign tif.step_up   = angle_valid_i && sector_change && forward
                      && tstate_q == angle_status_pkg::TALLY_TRACK
                      && !pol_change;
  assign tif.step_down = angle_valid_i && sector_change && !forward
                      && tstate_q == angle_status_pkg::TALLY_TRACK
                      && !pol_change;
  assign tif.clear     = 1'b0;

  turns_tally u_tally (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tif     (tif)
  );

  // ==========================================================
  // Flag clear command
  // The command bit is never stored, so it always reads back zero
  assign flag_clear = wr_en_i
    && addr_is(wr_addr_i, angle_status_pkg::CONTROL_OFS)
    && wr_data_i[angle_status_pkg::FLAG_CLEAR_BIT];

  // ==========================================================
  // Primary fault flags
  always_comb begin
    primary_set = 7'h00;
    primary_set[angle_status_pkg::NVM_UNCORR_BIT]  =
      nvm_uncorrectable_i;
    primary_set[angle_status_pkg::NVM_CORR_BIT]    = nvm_corrected_i;
    primary_set[angle_status_pkg::OVERTEMP_BIT]    =
      async_lvl[angle_status_pkg::ASYNC_TEMP];
    primary_set[angle_status_pkg::TALLY_OVF_BIT]   = tif.overflow;
    primary_set[angle_status_pkg::LOGIC_FAULT_BIT] = logic_fault_i;
    primary_set[angle_status_pkg::FIELD_LOSS_BIT]  =
      field_valid_i && (field_level_i < field_loss_threshold_i);
    primary_set[angle_status_pkg::SUPPLY_LOSS_BIT] =
      async_lvl[angle_status_pkg::ASYNC_SUPPLY] | transport_exit_i;
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_q <= angle_status_pkg::PRIMARY_RESET;
    end else begin
      primary_q <= sticky_next(primary_q, primary_set, flag_clear);
    end
  end

  // ==========================================================
  // Secondary fault flags
  always_comb begin
    secondary_set = 7'h00;
    secondary_set[angle_status_pkg::LINK_FAULT_BIT]    =
      serial_link_fault_i;
    secondary_set[angle_status_pkg::SELFTEST_FAIL_BIT] =
      logic_selftest_fail_i;
    secondary_set[angle_status_pkg::FRONTEND_FAIL_BIT] =
      frontend_selftest_fail_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      secondary_q <= angle_status_pkg::SECONDARY_RESET;
    end else begin
      secondary_q <= sticky_next(secondary_q, secondary_set, flag_clear)
                   & angle_status_pkg::SECONDARY_STICKY;
    end
  end

  // Factory bits are fixed and carry no user function
  assign secondary_view = secondary_q
                        | angle_status_pkg::FACTORY_BITS;

  // ==========================================================
  // Summary error
  // Factory bits are left out of the summary
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= any_unmasked(primary_q, fault_mask_primary_i)
        | any_unmasked(secondary_q, fault_mask_secondary_i);
    end
  end

  assign summary_error_o = summary_q;

  // ==========================================================
  // Register read
  // Reads only select data; no flag or count changes on a read
  always_comb begin
    rd_mux = 13'h0000;
    case (1'b1)
      addr_is(rd_addr_i, angle_status_pkg::ANGLE_READING_OFS): begin
        rd_mux = {angle_q, 1'b0};
      end
      addr_is(rd_addr_i, angle_status_pkg::TURNS_TALLY_OFS): begin
        rd_mux = {1'b0, tif.count};
      end
      addr_is(rd_addr_i, angle_status_pkg::FAULT_PRIMARY_OFS): begin
        rd_mux = {6'h00, primary_q};
      end
      addr_is(rd_addr_i, angle_status_pkg::FAULT_SECONDARY_OFS): begin
        rd_mux = {6'h00, secondary_view};
      end
      default: begin
        rd_mux = 13'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= 13'h0000;
    end else if (rd_en_i) begin
      rd_data_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en_i;
    end
  end

  assign rd_data_o  = rd_data_q;
  assign rd_valid_o = rd_valid_q;

endmodule // angle_status_regs

/* hdl/angle_status_pkg.sv */
// Shared constants of the angle, turns and fault status register bank
package angle_status_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W              = 6;
  localparam int unsigned REG_W               = 13;
  localparam logic [5:0]  ANGLE_READING_OFS   = 6'h00;
  localparam logic [5:0]  TURNS_TALLY_OFS     = 6'h02;
  localparam logic [5:0]  FAULT_PRIMARY_OFS   = 6'h04;
  localparam logic [5:0]  FAULT_SECONDARY_OFS = 6'h05;
  localparam logic [5:0]  CONTROL_OFS         = 6'h08;
  localparam int unsigned FLAG_CLEAR_BIT      = 0;

  // ==========================================================
  // Angle and tally fields
  localparam int unsigned ANGLE_W     = 12;
  localparam int unsigned ANGLE_LSB   = 1;
  localparam int unsigned TALLY_W     = 12;
  localparam logic [11:0] TALLY_MAX   = 12'h500;
  localparam logic [11:0] TALLY_MIN   = 12'hb00;
  localparam logic [11:0] TALLY_RESET = 12'h000;

  // ==========================================================
  // Fault flag fields
  localparam int unsigned FLAG_W             = 7;
  localparam int unsigned SUPPLY_LOSS_BIT    = 0;
  localparam int unsigned FIELD_LOSS_BIT     = 1;
  localparam int unsigned LOGIC_FAULT_BIT    = 2;
  localparam int unsigned TALLY_OVF_BIT      = 3;
  localparam int unsigned OVERTEMP_BIT       = 4;
  localparam int unsigned NVM_CORR_BIT       = 5;
  localparam int unsigned NVM_UNCORR_BIT     = 6;
  localparam int unsigned FACTORY_ZERO_BIT   = 0;
  localparam int unsigned FACTORY_ONE_BIT    = 1;
  localparam int unsigned FRONTEND_FAIL_BIT  = 3;
  localparam int unsigned SELFTEST_FAIL_BIT  = 4;
  localparam int unsigned LINK_FAULT_BIT     = 6;
  localparam logic [6:0]  PRIMARY_RESET      = 7'h01;
  localparam logic [6:0]  SECONDARY_RESET    = 7'h00;
  localparam logic [6:0]  FACTORY_BITS       = 7'h01;
  localparam logic [6:0]  SECONDARY_STICKY   = 7'h58;

  // ==========================================================
  // Input conditioning
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned ASYNC_N     = 2;
  localparam int unsigned ASYNC_TEMP  = 0;
  localparam int unsigned ASYNC_SUPPLY = 1;

  typedef enum logic [1:0] {
    TALLY_WAIT  = 2'b01,
    TALLY_TRACK = 2'b10
  } tally_state_t;

endpackage

/* hdl/tally_if.sv */
// Carrier between the bank and its turns tally counter
interface tally_if;
  logic        step_up;
  logic        step_down;
  logic        clear;
  logic [11:0] count;
  logic        overflow;

  modport counter (
    input  step_up,
    input  step_down,
    input  clear,
    output count,
    output overflow
  );

  modport user (
    output step_up,
    output step_down,
    output clear,
    input  count,
    input  overflow
  );
endinterface

/* hdl/turns_tally.sv */
// Saturating signed turns tally with overflow pulse
module turns_tally (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  tally_if.counter  tif
);

  logic [11:0] count_q;
  logic        overflow_q;

  assign tif.count    = count_q;
  assign tif.overflow = overflow_q;

  // ==========================================================
  // Count
  // Saturates at the documented span so the value never wraps sign
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= angle_status_pkg::TALLY_RESET;
    end else if (tif.clear) begin
      count_q <= angle_status_pkg::TALLY_RESET;
    end else if (tif.step_up) begin
      if (count_q != angle_status_pkg::TALLY_MAX) begin
        count_q <= count_q + 12'h001;
      end
    end else if (tif.step_down) begin
      if (count_q != angle_status_pkg::TALLY_MIN) begin
        count_q <= count_q - 12'h001;
      end
    end
  end

  // ==========================================================
  // Overflow
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= (tif.step_up && count_q == angle_status_pkg::TALLY_MAX)
        || (tif.step_down && count_q == angle_status_pkg::TALLY_MIN);
    end
  end

endmodule // turns_tally

/* sim/angle_status_sva.sv */
// Port assertions for the angle, turns and fault status bank
module angle_status_sva (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        rd_en_i,
  input wire logic [5:0]  rd_addr_i,
  input wire logic [12:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        wr_en_i,
  input wire logic [5:0]  wr_addr_i,
  input wire logic [12:0] wr_data_i,
  input wire logic        nvm_uncorrectable_i,
  input wire logic [6:0]  fault_mask_primary_i,
  input wire logic [6:0]  fault_mask_secondary_i,
  input wire logic        summary_error_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic clr_w;
  assign clr_w = wr_en_i && wr_addr_i == 6'h08 && wr_data_i[0];
  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered");
  a_read_single: assert property (!rd_en_i |=> !rd_valid_o)
    else $error("answer without read");
  a_angle_lsb: assert property (
    rd_valid_o && $past(rd_addr_i) == 6'h00 |-> !rd_data_o[0])
    else $error("angle bit 0 set");
  a_tally_top: assert property (
    rd_valid_o && $past(rd_addr_i) == 6'h02 |-> !rd_data_o[12])
    else $error("tally bit 12 set");
  a_primary_top: assert property (
    rd_valid_o && $past(rd_addr_i) == 6'h04 |-> rd_data_o[12:7] == 6'h00)
    else $error("primary upper bits set");
  a_factory_bits: assert property (
    rd_valid_o && $past(rd_addr_i) == 6'h05 |-> rd_data_o[12:7] == 6'h00
    && !rd_data_o[5] && rd_data_o[2:0] == 3'h1)
    else $error("secondary fixed bits wrong");
  a_unmapped_zero: assert property (
    rd_valid_o && !($past(rd_addr_i) inside {6'h00, 6'h02, 6'h04, 6'h05})
    |-> rd_data_o == 13'h0000) else $error("unmapped read not zero");
  a_event_summary: assert property (
    nvm_uncorrectable_i ##1 !fault_mask_primary_i[6] |=> summary_error_o)
    else $error("fault without summary");
  a_masked_quiet: assert property (
    fault_mask_primary_i == 7'h7f && fault_mask_secondary_i == 7'h7f
    |=> !summary_error_o) else $error("summary while all masked");
  // A flag can only leave through a clear, so a fall needs a cause
  a_sticky_fall: assert property (
    $fell(summary_error_o) |-> $past(clr_w, 2)
    || $past(fault_mask_primary_i) != $past(fault_mask_primary_i, 2)
    || $past(fault_mask_secondary_i) != $past(fault_mask_secondary_i, 2))
    else $error("summary fell without clear");
  a_supply_start: assert property (
    $rose(rst_n_i) && !fault_mask_primary_i[0] |=> summary_error_o)
    else $error("no summary after reset");
  c_second_read: cover property (rd_valid_o && $past(rd_addr_i) == 6'h05);
  c_clear_drop: cover property (clr_w ##2 $fell(summary_error_o));
  c_summary_up: cover property ($rose(summary_error_o));
endmodule // angle_status_sva

bind angle_status_regs angle_status_sva u_angle_status_sva (
  .clk_i, .rst_n_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o,
  .wr_en_i, .wr_addr_i, .wr_data_i, .nvm_uncorrectable_i,
  .fault_mask_primary_i, .fault_mask_secondary_i, .summary_error_o);

/* sim/host_model.sv */
// Host side: register reads and control writes on the bank port
module host_model (
  input  wire logic        clk_i,
  input  wire logic        valid_i,
  input  wire logic [12:0] data_i,
  output logic             rd_en_o,
  output logic      [5:0]  rd_addr_o,
  output logic             wr_en_o,
  output logic      [5:0]  wr_addr_o,
  output logic      [12:0] wr_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Bus cycles
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 6'h00;
    wr_en_o   = 1'b0;
    wr_addr_o = 6'h00;
    wr_data_o = 13'h0000;
  end
  // Address is scrambled once taken, so a late use shows up
  task automatic rd(input logic [5:0] a, output logic [12:0] d,
                    output logic ok);
    @(posedge clk_i);
    rd_en_o   <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_i);
    rd_en_o   <= 1'b0;
    rd_addr_o <= ~a;
    @(negedge clk_i);
    d  = data_i;
    ok = valid_i;
  endtask
  task automatic wr(input logic [5:0] a, input logic [12:0] d);
    @(posedge clk_i);
    wr_en_o   <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o   <= 1'b0;
    wr_data_o <= ~d;
  endtask
  // Supply-loss flag is cleared before normal use
  task automatic start();
    wr(6'h08, 13'h0001);
  endtask
endmodule // host_model

/* sim/angle_status_regs_tb.sv */
// Self-checking bench of the angle, turns and fault status bank
module angle_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        rd_en_i, rd_valid_o, wr_en_i, summary_error_o;
  logic        angle_valid_i = 1'b0;
  logic        rotation_polarity_i = 1'b0;
  logic        tally_step_select_i = 1'b0;
  logic [5:0]  rd_addr_i, wr_addr_i;
  logic [12:0] rd_data_o, wr_data_i;
  logic [11:0] angle_raw_i = 12'h000;
  logic [10:0] field_level_i = 11'h0f3;
  logic [10:0] field_loss_threshold_i = 11'h5a4;
  logic [9:0]  ev = 10'h000;
  logic [6:0]  fault_mask_primary_i = 7'h00;
  logic [6:0]  fault_mask_secondary_i = 7'h00;
  logic [31:0] seed = 32'he2a10832;
  int          n_errors = 0;
  int          total_checks = 0;
  // Bit of {secondary, primary} set by each line of ev
  localparam int EBIT [10] = '{0, 6, 5, 4, 2, 13, 11, 10, 0, 1};
  always #50 clk_i = ~clk_i;
  angle_status_regs u_angle_status_regs (
    .clk_i, .rst_n_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o,
    .wr_en_i, .wr_addr_i, .wr_data_i, .angle_valid_i, .angle_raw_i,
    .rotation_polarity_i, .tally_step_select_i, .field_valid_i(ev[9]),
    .field_level_i, .field_loss_threshold_i, .supply_loss_i(ev[0]),
    .nvm_uncorrectable_i(ev[1]), .nvm_corrected_i(ev[2]),
    .overtemp_i(ev[3]), .logic_fault_i(ev[4]),
    .serial_link_fault_i(ev[5]), .logic_selftest_fail_i(ev[6]),
    .frontend_selftest_fail_i(ev[7]), .transport_exit_i(ev[8]),
    .fault_mask_primary_i, .fault_mask_secondary_i, .summary_error_o);
  host_model u_host_model (
    .clk_i, .valid_i(rd_valid_o), .data_i(rd_data_o), .rd_en_o(rd_en_i),
    .rd_addr_o(rd_addr_i), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] sect(input logic [11:0] v, input logic s);
    return s ? v[11:9] : {2'b00, v[11]};
  endfunction
  task automatic chk(input string nm, input logic [12:0] e,
                     input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [12:0] e);
    logic [12:0] d;
    logic        ok;
    u_host_model.rd(a, d, ok);
    chk("rd_valid_o", 13'h0001, {12'h000, ok});
    chk("rd_data_o", e, d);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Random walk of under half a turn per sample, or a steady climb
  task automatic run(input logic p, input logic s, input int n,
                     input logic up);
    logic [31:0] d;
    logic [11:0] a, st, pv, df, cnt;
    logic        ov;
    do_reset();
    rotation_polarity_i <= p;
    tally_step_select_i <= s;
    d   = xs();
    a   = d[11:0];
    pv  = 12'h000;
    cnt = 12'h000;
    ov  = 1'b0;
    for (int i = 0; i < n; i++) begin
      d = xs();
      if (i > 0) begin
        a = up ? a + 12'h1c0 : d[10] ? a - 12'(d[9:0]) : a + 12'(d[9:0]);
      end
      @(posedge clk_i);
      angle_valid_i <= 1'b1;
      angle_raw_i   <= a;
      @(posedge clk_i);
      angle_valid_i <= 1'b0;
      st = p ? 12'h000 - a : a;
      df = st - pv;
      if (i > 0 && sect(st, s) != sect(pv, s)) begin
        if (!df[11] && cnt == 12'h500 || df[11] && cnt == 12'hb00) begin
          ov = 1'b1;
        end else begin
          cnt = df[11] ? cnt - 12'h001 : cnt + 12'h001;
        end
      end
      pv = st;
      if (!up || i == n - 1) begin
        repeat (3) @(posedge clk_i);
        rdc(6'h00, {st, 1'b0});
        rdc(6'h02, {1'b0, cnt});
        rdc(6'h04, {9'h000, ov, 3'h1});
      end
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [13:0] e;
    do_reset();
    rdc(6'h00, 13'h0000);
    rdc(6'h02, 13'h0000);
    rdc(6'h04, 13'h0001);
    rdc(6'h05, 13'h0001);
    rdc(6'h3f, 13'h0000);
    chk("summary_error_o", 13'h0001, {12'h000, summary_error_o});
    u_host_model.wr(6'h04, 13'h0001);
    u_host_model.wr(6'h08, 13'h1ffe);
    rdc(6'h04, 13'h0001);
    u_host_model.start();
    rdc(6'h04, 13'h0000);
    rdc(6'h08, 13'h0000);
    for (int k = 0; k < 10; k++) begin
      e = 14'h0001 << EBIT[k];
      @(posedge clk_i);
      fault_mask_primary_i   <= k == 3 ? 7'h7f : 7'(xs()) & 7'h3f;
      fault_mask_secondary_i <= k == 3 ? 7'h7f : 7'(xs());
      ev <= 10'h001 << k;
      repeat (4) @(posedge clk_i);
      ev <= 10'h000;
      repeat (3) @(posedge clk_i);
      rdc(6'h04, {6'h00, e[6:0]});
      rdc(6'h04, {6'h00, e[6:0]});
      rdc(6'h05, {6'h00, e[13:7] | 7'h01});
      chk("summary_error_o", {12'h000, |(e[6:0] & ~fault_mask_primary_i)
        | |(e[13:7] & ~fault_mask_secondary_i)},
        {12'h000, summary_error_o});
      u_host_model.wr(6'h08, 13'h0001);
      rdc(6'h04, 13'h0000);
      rdc(6'h05, 13'h0001);
    end
    // Field exactly at the threshold is not a loss
    @(posedge clk_i);
    field_level_i <= field_loss_threshold_i;
    ev            <= 10'h200;
    repeat (2) @(posedge clk_i);
    ev            <= 10'h000;
    rdc(6'h04, 13'h0000);
    for (int r = 0; r < 6; r++) begin
      run(r[0], r[1] || r > 3, r > 3 ? 1600 : 40, r > 3);
    end
    wrap_up();
  end
  // Longest path is about 8500 cycles; allow about seven times that
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule // angle_status_regs_tb
